/* hw/epf_defs.vh */
// Overview of operation
// - frames: escape, identifier, payload, escape, end
// - identifier never escape or end value
// - stuff and unstuff payload escape bytes
// - end only after odd escape run
// - multi-byte numbers sent high byte first
// - integer is two-byte two's complement
// - single is four-byte float, hidden one
// - double is eight-byte float
// - offset command 43 hex clears offset
// - offset command four bytes loads offset
// - reset byte selects reset kind
// - cold reset clears volatile navigation data
// - factory resets erase position, restart survey
// - version, time, fix mode requests answer
// - health request answers two reports
// - almanac request answers report 40
// - initial position ignored while computing
// - soft reset self-tests, emits startup reports
// - version report only on reset or request
// - discrete commands send no response
`ifndef EPF_DEFS_VH
`define EPF_DEFS_VH
`define EPF_ESC          8'h10
`define EPF_END          8'h03
`define EPF_CMD_OSC      8'h1D
`define EPF_CMD_RESET    8'h1E
`define EPF_CMD_VERSION  8'h1F
`define EPF_CMD_ALMANAC  8'h20
`define EPF_CMD_TIME     8'h21
`define EPF_CMD_POS_XYZ  8'h23
`define EPF_CMD_FIXMODE  8'h24
`define EPF_CMD_SOFTRST  8'h25
`define EPF_CMD_HEALTH   8'h26
`define EPF_CMD_SIGNAL   8'h27
`define EPF_CMD_SYSMSG   8'h28
`define EPF_CMD_ALMHLTH  8'h29
`define EPF_CMD_POS_LLA  8'h2B
`define EPF_RPT_ALMANAC  8'h40
`define EPF_RPT_TIME     8'h41
`define EPF_RPT_VERSION  8'h45
`define EPF_RPT_HEALTH   8'h46
`define EPF_RPT_SIGNAL   8'h47
`define EPF_RPT_SYSMSG   8'h48
`define EPF_RPT_ALMHLTH  8'h49
`define EPF_RPT_MACHINE  8'h4B
`define EPF_RPT_FIXMODE  8'h6D
`define EPF_OP_CLEAR     8'h43
`define EPF_RST_COLD     8'h4B
`define EPF_RST_FACTORY  8'h46
`define EPF_RST_COMPAT   8'h43
`define EPF_RST_NAVCLR   8'h4E
`define EPF_RST_DEFCFG   8'h52
`define EPF_FIFO_DEPTH   4
`define EPF_FIFO_AW      2
`define EPF_PAY_MAX      12
`endif

/* hw/epf_fifo.v */
`timescale 1ns/1ps
module epf_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   // clock and reset
   input  wire             sys_clk,
   input  wire             rst,
   // fill side
   input  wire             inValid,
   output wire             inReady,
   input  wire [WIDTH-1:0] inData,
   // drain side
   output wire             outValid,
   input  wire             outReady,
   output reg  [WIDTH-1:0] outData
);
   reg  [WIDTH-1:0] mem [0:DEPTH-1];
   reg  [AW-1:0]    wrPtr_r;
   reg  [AW-1:0]    rdPtr_r;
   reg  [AW:0]      count_r;
   reg              outValid_r;
   wire             doWr;
   wire             doRd;
   wire             memHas;
   wire             load;

   // one word sits in outData; the rest in mem, so read data come from a register
   assign memHas   = (count_r != {(AW+1){1'b0}});
   assign load     = memHas & (~outValid_r | outReady);
   assign outValid = outValid_r;
   assign inReady  = (count_r != DEPTH[AW:0]);
   assign doWr     = inValid & inReady;
   assign doRd     = load;

   always @(posedge sys_clk) begin
      if (doWr) begin
         mem[wrPtr_r] <= inData;
      end
   end

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wrPtr_r    <= {AW{1'b0}};
         rdPtr_r    <= {AW{1'b0}};
         count_r    <= {(AW+1){1'b0}};
         outValid_r <= 1'b0;
         outData    <= {WIDTH{1'b0}};
      end else begin
         if (doWr) begin
            wrPtr_r <= wrPtr_r + {{(AW-1){1'b0}}, 1'b1};
         end
         if (doRd) begin
            rdPtr_r <= rdPtr_r + {{(AW-1){1'b0}}, 1'b1};
            outData <= mem[rdPtr_r];
         end
         if (doWr & ~doRd) begin
            count_r <= count_r + {{AW{1'b0}}, 1'b1};
         end else if (doRd & ~doWr) begin
            count_r <= count_r - {{AW{1'b0}}, 1'b1};
         end
         if (load) begin
            outValid_r <= 1'b1;
         end else if (outReady) begin
            outValid_r <= 1'b0;
         end
      end
   end
endmodule // epf_fifo

/* hw/epf_tx_framer.v */
`timescale 1ns/1ps
`include "epf_defs.vh"
module epf_tx_framer (
   // clock and reset
   input  wire       sys_clk,
   input  wire       rst,
   // report request
   input  wire       rptValid,
   output wire       rptReady,
   input  wire [7:0] rptId,
   input  wire [7:0] rptArg,
   // outgoing byte stream
   output reg        txValid,
   input  wire       txReady,
   output reg  [7:0] txData
);
   localparam S_IDLE = 6'b000001;
   localparam S_ID   = 6'b000010;
   localparam S_ARG  = 6'b000100;
   localparam S_STUF = 6'b001000;
   localparam S_ESC  = 6'b010000;
   localparam S_END  = 6'b100000;

   reg  [5:0] state_r;
   reg  [7:0] id_r;
   reg  [7:0] arg_r;
   reg        hasArg_r;

   // wait for the held end byte to leave, else the report is lost
   assign rptReady = (state_r == S_IDLE) && (!txValid || txReady);

   // a report carries one argument byte only for the almanac report
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_r  <= S_IDLE;
         id_r     <= 8'h00;
         arg_r    <= 8'h00;
         hasArg_r <= 1'b0;
         txValid  <= 1'b0;
         txData   <= 8'h00;
      end else begin
         if (!txValid || txReady) begin
            txValid <= 1'b0;
            case (state_r)
               S_IDLE: begin
                  if (rptValid) begin
                     id_r     <= rptId;
                     arg_r    <= rptArg;
                     hasArg_r <= (rptId == `EPF_RPT_ALMANAC);
                     txValid  <= 1'b1;
                     txData   <= `EPF_ESC;
                     state_r  <= S_ID;
                  end
               end
               S_ID: begin
                  txValid <= 1'b1;
                  txData  <= id_r;
                  state_r <= hasArg_r ? S_ARG : S_ESC;
               end
               S_ARG: begin
                  txValid <= 1'b1;
                  txData  <= arg_r;
                  state_r <= (arg_r == `EPF_ESC) ? S_STUF : S_ESC;
               end
               S_STUF: begin
                  txValid <= 1'b1;
                  txData  <= `EPF_ESC;
                  state_r <= S_ESC;
               end
               S_ESC: begin
                  txValid <= 1'b1;
                  txData  <= `EPF_ESC;
                  state_r <= S_END;
               end
               S_END: begin
                  txValid <= 1'b1;
                  txData  <= `EPF_END;
                  state_r <= S_IDLE;
               end
               default: begin
                  state_r <= S_IDLE;
               end
            endcase
         end
      end
   end
endmodule // epf_tx_framer

/* hw/escaped_packet_framer.v */
`timescale 1ns/1ps
`include "epf_defs.vh"
module escaped_packet_framer (
   // clock and reset
   input  wire        sys_clk,
   input  wire        rst,
   // incoming byte stream from host (pin side, asynchronous)
   input  wire        rxValid,
   input  wire [7:0]  rxData,
   // outgoing byte stream to host
   output wire        txValid,
   input  wire        txReady,
   output wire [7:0]  txData,
   // device status
   input  wire        navFixing,
   // oscillator offset store
   output reg         oscClear,
   output reg         oscLoad,
   output reg  [31:0] oscValue,
   // reset actions
   output reg         coldReset,
   output reg         factoryReset,
   output reg         compatRestart,
   output reg         navNvClear,
   output reg         cfgDefault,
   output reg         softReset,
   // initial position
   output reg         posLoad,
   output reg         posIsLla,
   output reg  [31:0] posA,
   output reg  [31:0] posB,
   output reg  [31:0] posC,
   // almanac request
   output reg  [7:0]  satelliteCodeNumber
);
   localparam S_HUNT = 5'b00001;
   localparam S_ID   = 5'b00010;
   localparam S_DATA = 5'b00100;
   localparam S_ESC  = 5'b01000;
   localparam S_EXEC = 5'b10000;

   // synchronisers for the pin-side stream; valid toggles per byte
   reg        rxValSync1_r;
   reg        rxValSync2_r;
   reg        rxValSync3_r;
   reg [7:0]  rxDatSync1_r;
   reg [7:0]  rxDatSync2_r;
   wire       rxStrobe;

   reg [4:0]  state_r;
   reg [7:0]  id_r;
   reg [7:0]  pay_r [0:`EPF_PAY_MAX-1];
   reg [3:0]  len_r;
   reg        over_r;
   reg        startup_r;
   reg        second_r;
   reg        rptValid_r;
   reg [7:0]  rptId_r;
   reg [7:0]  rptArg_r;
   wire       rptReady;
   wire       fifoInReady;
   wire       fifoOutValid;
   wire       fifoOutReady;
   wire [7:0] fifoOutData;
   integer    i;

   // multi-byte numbers arrive high byte first
   function [31:0] beWord;
      input [7:0] b0;
      input [7:0] b1;
      input [7:0] b2;
      input [7:0] b3;
      begin
         beWord = {b0, b1, b2, b3};
      end
   endfunction

   function isFrameByte;
      input [7:0] b;
      begin
         isFrameByte = (b == `EPF_ESC) || (b == `EPF_END);
      end
   endfunction

   // rxValid toggles once per byte; data are held steady around the toggle
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rxValSync1_r <= 1'b0;
         rxValSync2_r <= 1'b0;
         rxValSync3_r <= 1'b0;
         rxDatSync1_r <= 8'h00;
         rxDatSync2_r <= 8'h00;
      end else begin
         rxValSync1_r <= rxValid;
         rxValSync2_r <= rxValSync1_r;
         rxValSync3_r <= rxValSync2_r;
         rxDatSync1_r <= rxData;
         rxDatSync2_r <= rxDatSync1_r;
      end
   end
   assign rxStrobe = rxValSync2_r ^ rxValSync3_r;

   // deframer: S_ESC means one unpaired escape seen, so end is taken only after odd runs
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_r <= S_HUNT;
         id_r    <= 8'h00;
         len_r   <= 4'h0;
         over_r  <= 1'b0;
         for (i = 0; i < `EPF_PAY_MAX; i = i + 1) begin
            pay_r[i] <= 8'h00;
         end
      end else begin
         case (state_r)
            S_HUNT: begin
               if (rxStrobe && rxDatSync2_r == `EPF_ESC) begin
                  state_r <= S_ID;
               end
            end
            S_ID: begin
               if (rxStrobe) begin
                  len_r  <= 4'h0;
                  over_r <= 1'b0;
                  id_r   <= rxDatSync2_r;
                  // identifier may not be a framing value
                  if (isFrameByte(rxDatSync2_r)) begin
                     state_r <= S_HUNT;
                  end else begin
                     state_r <= S_DATA;
                  end
               end
            end
            S_DATA: begin
               if (rxStrobe) begin
                  if (rxDatSync2_r == `EPF_ESC) begin
                     state_r <= S_ESC;
                  end else begin
                     if (len_r == `EPF_PAY_MAX) begin
                        over_r <= 1'b1;
                     end else begin
                        pay_r[len_r] <= rxDatSync2_r;
                        len_r        <= len_r + 4'h1;
                     end
                  end
               end
            end
            S_ESC: begin
               if (rxStrobe) begin
                  if (rxDatSync2_r == `EPF_ESC) begin
                     // stuffed pair keeps one escape as payload
                     if (len_r == `EPF_PAY_MAX) begin
                        over_r <= 1'b1;
                     end else begin
                        pay_r[len_r] <= `EPF_ESC;
                        len_r        <= len_r + 4'h1;
                     end
                     state_r <= S_DATA;
                  end else if (rxDatSync2_r == `EPF_END) begin
                     state_r <= S_EXEC;
                  end else begin
                     // lone escape starts a new frame; this byte is its identifier
                     len_r   <= 4'h0;
                     over_r  <= 1'b0;
                     id_r    <= rxDatSync2_r;
                     state_r <= S_DATA;
                  end
               end
            end
            S_EXEC: begin
               // wait until the reply path can take the reports
               if (!rptValid_r && rptReady && !second_r) begin
                  state_r <= S_HUNT;
               end
            end
            default: begin
               state_r <= S_HUNT;
            end
         endcase
      end
   end

   // command decode; a byte arriving while in S_EXEC is dropped (host paces commands)
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         oscClear            <= 1'b0;
         oscLoad             <= 1'b0;
         oscValue            <= 32'h00000000;
         coldReset           <= 1'b0;
         factoryReset        <= 1'b0;
         compatRestart       <= 1'b0;
         navNvClear          <= 1'b0;
         cfgDefault          <= 1'b0;
         softReset           <= 1'b0;
         posLoad             <= 1'b0;
         posIsLla            <= 1'b0;
         posA                <= 32'h00000000;
         posB                <= 32'h00000000;
         posC                <= 32'h00000000;
         satelliteCodeNumber <= 8'h00;
         startup_r           <= 1'b1;
         second_r            <= 1'b0;
         rptValid_r          <= 1'b0;
         rptId_r             <= 8'h00;
         rptArg_r            <= 8'h00;
      end else begin
         oscClear      <= 1'b0;
         oscLoad       <= 1'b0;
         coldReset     <= 1'b0;
         factoryReset  <= 1'b0;
         compatRestart <= 1'b0;
         navNvClear    <= 1'b0;
         cfgDefault    <= 1'b0;
         softReset     <= 1'b0;
         posLoad       <= 1'b0;
         if (rptValid_r && rptReady) begin
            rptValid_r <= 1'b0;
         end
         if (startup_r) begin
            // version report once after reset release
            startup_r  <= 1'b0;
            rptValid_r <= 1'b1;
            rptId_r    <= `EPF_RPT_VERSION;
         end else if (second_r && !rptValid_r) begin
            second_r   <= 1'b0;
            rptValid_r <= 1'b1;
            rptId_r    <= `EPF_RPT_MACHINE;
         end else if (state_r == S_EXEC && !rptValid_r && rptReady && !over_r) begin
            if (id_r == `EPF_CMD_OSC && len_r == 4'd1 && pay_r[0] == `EPF_OP_CLEAR) begin
               oscClear <= 1'b1;
            end else if (id_r == `EPF_CMD_OSC && len_r == 4'd4) begin
               oscLoad  <= 1'b1;
               oscValue <= beWord(pay_r[0], pay_r[1], pay_r[2], pay_r[3]);
            end else if (id_r == `EPF_CMD_RESET && len_r == 4'd1) begin
               // cold and navigation-clear both power-cycle the volatile state
               if (pay_r[0] == `EPF_RST_COLD) begin
                  coldReset <= 1'b1;
               end else if (pay_r[0] == `EPF_RST_FACTORY) begin
                  factoryReset <= 1'b1;
               end else if (pay_r[0] == `EPF_RST_COMPAT) begin
                  compatRestart <= 1'b1;
               end else if (pay_r[0] == `EPF_RST_NAVCLR) begin
                  navNvClear <= 1'b1;
                  coldReset  <= 1'b1;
               end else if (pay_r[0] == `EPF_RST_DEFCFG) begin
                  cfgDefault <= 1'b1;
               end
            end else if (id_r == `EPF_CMD_VERSION && len_r == 4'd0) begin
               rptValid_r <= 1'b1;
               rptId_r    <= `EPF_RPT_VERSION;
            end else if (id_r == `EPF_CMD_TIME && len_r == 4'd0) begin
               rptValid_r <= 1'b1;
               rptId_r    <= `EPF_RPT_TIME;
            end else if (id_r == `EPF_CMD_FIXMODE && len_r == 4'd0) begin
               rptValid_r <= 1'b1;
               rptId_r    <= `EPF_RPT_FIXMODE;
            end else if (id_r == `EPF_CMD_HEALTH && len_r == 4'd0) begin
               rptValid_r <= 1'b1;
               rptId_r    <= `EPF_RPT_HEALTH;
               second_r   <= 1'b1;
            end else if (id_r == `EPF_CMD_SIGNAL && len_r == 4'd0) begin
               rptValid_r <= 1'b1;
               rptId_r    <= `EPF_RPT_SIGNAL;
            end else if (id_r == `EPF_CMD_SYSMSG && len_r == 4'd0) begin
               rptValid_r <= 1'b1;
               rptId_r    <= `EPF_RPT_SYSMSG;
            end else if (id_r == `EPF_CMD_ALMHLTH && len_r == 4'd0) begin
               rptValid_r <= 1'b1;
               rptId_r    <= `EPF_RPT_ALMHLTH;
            end else if (id_r == `EPF_CMD_ALMANAC && len_r == 4'd1) begin
               satelliteCodeNumber <= pay_r[0];
               rptValid_r          <= 1'b1;
               rptId_r             <= `EPF_RPT_ALMANAC;
               rptArg_r            <= pay_r[0];
            end else if ((id_r == `EPF_CMD_POS_XYZ || id_r == `EPF_CMD_POS_LLA)
                         && len_r == 4'd12) begin
               // position hint is useless once fixes run
               if (!navFixing) begin
                  posLoad  <= 1'b1;
                  posIsLla <= (id_r == `EPF_CMD_POS_LLA);
                  posA     <= beWord(pay_r[0], pay_r[1], pay_r[2], pay_r[3]);
                  posB     <= beWord(pay_r[4], pay_r[5], pay_r[6], pay_r[7]);
                  posC     <= beWord(pay_r[8], pay_r[9], pay_r[10], pay_r[11]);
               end
            end else if (id_r == `EPF_CMD_SOFTRST && len_r == 4'd0) begin
               softReset  <= 1'b1;
               rptValid_r <= 1'b1;
               rptId_r    <= `EPF_RPT_VERSION;
            end
            // anything else is dropped without a reply
         end
      end
   end

   epf_tx_framer u_tx (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .rptValid (rptValid_r),
      .rptReady (rptReady),
      .rptId    (rptId_r),
      .rptArg   (rptArg_r),
      .txValid  (fifoOutValid),
      .txReady  (fifoInReady),
      .txData   (fifoOutData)
   );

   // fifo absorbs host stalls; framer holds its byte while full
   epf_fifo #(
      .WIDTH (8),
      .DEPTH (`EPF_FIFO_DEPTH),
      .AW    (`EPF_FIFO_AW)
   ) u_fifo (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .inValid  (fifoOutValid),
      .inReady  (fifoInReady),
      .inData   (fifoOutData),
      .outValid (txValid),
      .outReady (fifoOutReady),
      .outData  (txData)
   );
   assign fifoOutReady = txReady;
endmodule // escaped_packet_framer

/* verif/epf_chk.sv */
`timescale 1ns/1ps
`include "epf_defs.vh"
module epf_chk (
   // clock and reset
   input wire        sys_clk,
   input wire        rst,
   // byte stream to host
   input wire        txValid,
   input wire        txReady,
   input wire [7:0]  txData,
   // status and actions
   input wire        navFixing,
   input wire        oscClear,
   input wire        oscLoad,
   input wire [31:0] oscValue,
   input wire        coldReset,
   input wire        factoryReset,
   input wire        compatRestart,
   input wire        navNvClear,
   input wire        cfgDefault,
   input wire        softReset,
   input wire        posLoad,
   input wire [31:0] posA
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   wire acc = txValid && txReady;
   reg  idle_r;
   reg  startId_r;
   reg  oddEsc_r;
   // tracks the framing state of accepted output bytes
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         idle_r    <= 1'b1;
         startId_r <= 1'b0;
         oddEsc_r  <= 1'b0;
      end else if (acc) begin
         if (idle_r) begin
            idle_r    <= 1'b0;
            startId_r <= 1'b1;
         end else if (startId_r) begin
            startId_r <= 1'b0;
         end else if (txData == `EPF_ESC) begin
            oddEsc_r <= !oddEsc_r;
         end else begin
            idle_r   <= oddEsc_r && txData == `EPF_END;
            oddEsc_r <= 1'b0;
         end
      end
   end
   sequence sVersionOut;
      ##[1:600] (acc && txData == `EPF_RPT_VERSION);
   endsequence
   a_tx_start: assert property (idle_r && acc |-> txData == `EPF_ESC)
      else $error("frame does not open with escape");
   a_tx_id: assert property (startId_r && acc
      |-> txData != `EPF_ESC && txData != `EPF_END)
      else $error("illegal identifier byte");
   a_tx_stuff: assert property (!idle_r && !startId_r && oddEsc_r && acc
      |-> txData == `EPF_ESC || txData == `EPF_END)
      else $error("unstuffed escape in payload");
   a_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txData))
      else $error("byte dropped while host stalls");
   a_osc_value: assert property ($changed(oscValue) |-> oscLoad || $past(oscLoad))
      else $error("offset changed without load");
   a_pos_value: assert property ($changed(posA) |-> posLoad || $past(posLoad))
      else $error("position changed without load");
   a_pos_ignore: assert property (posLoad |-> !$past(navFixing))
      else $error("position loaded while computing");
   a_nav_cold: assert property (navNvClear |-> coldReset)
      else $error("nav clear without cold reset");
   a_one_action: assert property ($onehot0({oscClear, oscLoad, coldReset, factoryReset,
      compatRestart, cfgDefault, softReset, posLoad}))
      else $error("several actions at once");
   a_soft_report: assert property (softReset |-> sVersionOut)
      else $error("no version report after soft reset");
endmodule // epf_chk
bind escaped_packet_framer epf_chk i_epf_chk (
   .sys_clk(sys_clk), .rst(rst), .txValid(txValid), .txReady(txReady), .txData(txData),
   .navFixing(navFixing), .oscClear(oscClear), .oscLoad(oscLoad), .oscValue(oscValue),
   .coldReset(coldReset), .factoryReset(factoryReset), .compatRestart(compatRestart),
   .navNvClear(navNvClear), .cfgDefault(cfgDefault), .softReset(softReset),
   .posLoad(posLoad), .posA(posA));

/* verif/epf_host.sv */
`timescale 1ns/1ps
`include "epf_defs.vh"
module epf_host (
   // clock
   input wire         sys_clk,
   // byte link
   output logic       rxValid,
   output logic [7:0] rxData,
   input wire         txValid,
   output logic       txReady,
   input wire  [7:0]  txData
);
   logic [7:0] rxq[$];
   logic [2:0] stall_r;
   initial begin
      rxValid = 1'b0;
      rxData  = 8'h00;
      txReady = 1'b0;
      stall_r = 3'h0;
   end
   // scrambles the data after the hold time so a stale byte never looks valid
   task sendByte(input logic [7:0] b);
      @(posedge sys_clk) rxData <= b;
      repeat (4) @(posedge sys_clk);
      rxValid <= !rxValid;
      repeat (4) @(posedge sys_clk);
      rxData <= ~b;
   endtask
   task sendFrame(input logic [7:0] id, input logic [7:0] pay[$]);
      sendByte(`EPF_ESC);
      sendByte(id);
      foreach (pay[i]) begin
         if (pay[i] == `EPF_ESC) sendByte(`EPF_ESC);
         sendByte(pay[i]);
      end
      sendByte(`EPF_ESC);
      sendByte(`EPF_END);
   endtask
   // stalls two beats in eight so held output bytes get exercised
   always @(posedge sys_clk) begin
      stall_r <= stall_r + 3'h1;
      txReady <= stall_r != 3'h5 && stall_r != 3'h6;
      if (txValid && txReady) rxq.push_back(txData);
   end
endmodule // epf_host

/* verif/tb.sv */
`timescale 1ns/1ps
`include "epf_defs.vh"
module tb;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic        navFixing = 1'b0;
   wire         rxValid, txValid, txReady;
   wire  [7:0]  rxData, txData, satelliteCodeNumber;
   wire         oscClear, oscLoad, coldReset, factoryReset, compatRestart;
   wire         navNvClear, cfgDefault, softReset, posLoad, posIsLla;
   wire  [31:0] oscValue, posA, posB, posC;
   wire  [8:0]  pv = {oscClear, oscLoad, coldReset, factoryReset, compatRestart,
                      navNvClear, cfgDefault, softReset, posLoad};
   int          err_total = 0;
   int          compares = 0;
   int          pc[9] = '{default: 0};
   logic [7:0]  none[$];
   always #2.5 sys_clk = !sys_clk;
   always @(posedge sys_clk) foreach (pc[i]) pc[i] <= pc[i] + pv[i];
   epf_host host (.sys_clk(sys_clk), .rxValid(rxValid), .rxData(rxData),
      .txValid(txValid), .txReady(txReady), .txData(txData));
   escaped_packet_framer i_escaped_packet_framer (.sys_clk(sys_clk), .rst(rst),
      .rxValid(rxValid), .rxData(rxData), .txValid(txValid), .txReady(txReady),
      .txData(txData), .navFixing(navFixing), .oscClear(oscClear), .oscLoad(oscLoad),
      .oscValue(oscValue), .coldReset(coldReset), .factoryReset(factoryReset),
      .compatRestart(compatRestart), .navNvClear(navNvClear), .cfgDefault(cfgDefault),
      .softReset(softReset), .posLoad(posLoad), .posIsLla(posIsLla), .posA(posA),
      .posB(posB), .posC(posC), .satelliteCodeNumber(satelliteCodeNumber));
   task check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t ns: got %h expected %h", $time, seen, exp);
      end
   endtask
   task conclude;
      $display("mismatches %0d, comparisons %0d", err_total, compares);
      if (err_total == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task waitRx(input int n);
      for (int k = 0; k < 3000 && host.rxq.size() < n; k++) @(posedge sys_clk);
   endtask
   task expectRpt(input logic [7:0] id);
      waitRx(4);
      check(host.rxq.pop_front(), `EPF_ESC);
      check(host.rxq.pop_front(), id);
      check(host.rxq.pop_front(), `EPF_ESC);
      check(host.rxq.pop_front(), `EPF_END);
   endtask
   // counts action pulses since the last call, then clears them
   task expectPulses(input logic [8:0] exp);
      repeat (200) @(posedge sys_clk);
      foreach (pc[i]) check(pc[i], exp[i]);
      @(negedge sys_clk) foreach (pc[i]) pc[i] = 0;
   endtask
   task t_boot;
      expectRpt(`EPF_RPT_VERSION);
      expectPulses(9'h000);
      check(host.rxq.size(), 0);
   endtask
   task t_requests;
      logic [7:0] req[6];
      logic [7:0] rpt[6];
      req = '{`EPF_CMD_VERSION, `EPF_CMD_TIME, `EPF_CMD_FIXMODE, `EPF_CMD_SIGNAL,
              `EPF_CMD_SYSMSG, `EPF_CMD_ALMHLTH};
      rpt = '{`EPF_RPT_VERSION, `EPF_RPT_TIME, `EPF_RPT_FIXMODE, `EPF_RPT_SIGNAL,
              `EPF_RPT_SYSMSG, `EPF_RPT_ALMHLTH};
      foreach (req[i]) begin
         host.sendFrame(req[i], none);
         expectRpt(rpt[i]);
      end
      host.sendFrame(`EPF_CMD_HEALTH, none);
      expectRpt(`EPF_RPT_HEALTH);
      expectRpt(`EPF_RPT_MACHINE);
      expectPulses(9'h000);
   endtask
   task t_almanac;
      logic [7:0] exp[6];
      exp = '{8'h10, 8'h40, 8'h10, 8'h10, 8'h10, 8'h03};
      host.sendFrame(`EPF_CMD_ALMANAC, '{`EPF_ESC});
      waitRx(6);
      foreach (exp[i]) check(host.rxq.pop_front(), exp[i]);
      check(satelliteCodeNumber, `EPF_ESC);
   endtask
   task t_osc;
      // escaped-valued byte then end value: even run, so payload
      host.sendFrame(`EPF_CMD_OSC, '{8'h10, 8'h03, 8'h00, 8'h7F});
      expectPulses(9'h080);
      check(oscValue, 32'h1003007F);
      host.sendFrame(`EPF_CMD_OSC, '{`EPF_OP_CLEAR});
      expectPulses(9'h100);
      check(host.rxq.size(), 0);
   endtask
   task t_reset;
      logic [7:0] code[5];
      logic [8:0] mask[5];
      code = '{`EPF_RST_COLD, `EPF_RST_FACTORY, `EPF_RST_COMPAT, `EPF_RST_NAVCLR,
               `EPF_RST_DEFCFG};
      mask = '{9'h040, 9'h020, 9'h010, 9'h048, 9'h004};
      foreach (code[i]) begin
         host.sendFrame(`EPF_CMD_RESET, '{code[i]});
         expectPulses(mask[i]);
      end
      check(host.rxq.size(), 0);
   endtask
   task t_soft;
      host.sendFrame(`EPF_CMD_SOFTRST, none);
      expectRpt(`EPF_RPT_VERSION);
      expectPulses(9'h002);
   endtask
   task t_pos;
      logic [7:0] p[$];
      p = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C};
      @(posedge sys_clk) navFixing <= 1'b1;
      host.sendFrame(`EPF_CMD_POS_LLA, p);
      expectPulses(9'h000);
      @(posedge sys_clk) navFixing <= 1'b0;
      host.sendFrame(`EPF_CMD_POS_LLA, p);
      expectPulses(9'h001);
      check(posIsLla, 1'b1);
      check(posA, 32'h01020304);
      check(posB, 32'h05060708);
      check(posC, 32'h090A0B0C);
   endtask
   task t_junk;
      host.sendFrame(8'h7E, none);
      expectPulses(9'h000);
      check(host.rxq.size(), 0);
      host.sendByte(`EPF_ESC);
      host.sendByte(`EPF_CMD_VERSION);
      host.sendFrame(`EPF_CMD_TIME, none);
      expectRpt(`EPF_RPT_TIME);
      expectPulses(9'h000);
      check(host.rxq.size(), 0);
   endtask
   initial begin
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      t_boot;
      t_requests;
      t_almanac;
      t_osc;
      t_reset;
      t_soft;
      t_pos;
      t_junk;
      conclude;
   end
   // the whole sequence needs well under half of this span
   initial begin
      repeat (90000) @(posedge sys_clk);
      err_total++;
      conclude;
   end
endmodule // tb
